// File: tcc_channel.v
// Capture and compare pin control of timer channel 1, register B, over APB.
`default_nettype none
`include "tcc_map.vh"
module tcc_channel #(
  parameter CNT_W = 16
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              pin_b_in,
  output reg               pin_b_out,
  output reg               pin_b_oe_n,
  input  wire              regc_ch0_event,
  input  wire              other_ch_event,
  output wire              irq
);
  // ---------------------------------------------------------------------------
  // Reset release: asserted at once, released through two flops.
  // ---------------------------------------------------------------------------
  reg rst_m_ff;
  reg rst_s_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_ff <= rst_m_ff;
    end
  end
  wire srst_n = rst_s_ff;

  // ---------------------------------------------------------------------------
  // Registers and decode.
  // ---------------------------------------------------------------------------
  reg  [7:0]       ioctl_ff;     // timer_io_control_ch1
  reg  [2:0]       ctrl_ff;      // run, clear-on-capture, source select
  reg  [CNT_W-1:0] count_ff;     // timer_counter_value
  reg  [CNT_W-1:0] regb_ff;      // general_reg_b_ch1
  reg  [1:0]       status_ff;
  reg  [1:0]       mask_ff;
  reg              ext_ev_m_ff;
  reg              ext_ev_s_ff;
  reg              ext_ev_l_ff;
  reg              regc_m_ff;
  reg              regc_s_ff;
  reg              regc_l_ff;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire known = (paddr == `TCC_OFF_IOCTL)  || (paddr == `TCC_OFF_CTRL) ||
               (paddr == `TCC_OFF_COUNT)  || (paddr == `TCC_OFF_REGB) ||
               (paddr == `TCC_OFF_STATUS) || (paddr == `TCC_OFF_MASK);

  // Zero wait states; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  wire [3:0] io_sel     = ioctl_ff[`TCC_IOSEL_MSB:`TCC_IOSEL_LSB];
  wire       mode_capt  = io_sel[3];
  wire       run        = ctrl_ff[`TCC_CTRL_RUN];
  wire       clr_on_b   = ctrl_ff[`TCC_CTRL_CLRB];
  wire       src_other  = ctrl_ff[`TCC_CTRL_SRC];

  // ---------------------------------------------------------------------------
  // Event inputs: pin edges, channel 0 register C and another channel.
  // ---------------------------------------------------------------------------
  wire pin_rise;
  wire pin_fall;
  tcc_edge_det u_pin_edge (
    .clk    (clk),
    .rst_n  (srst_n),
    .pin_in (pin_b_in),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // Event lines from other channels are treated as asynchronous levels.
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ext_ev_m_ff <= 1'b0;
      ext_ev_s_ff <= 1'b0;
      ext_ev_l_ff <= 1'b0;
      regc_m_ff   <= 1'b0;
      regc_s_ff   <= 1'b0;
      regc_l_ff   <= 1'b0;
    end else begin
      ext_ev_m_ff <= other_ch_event;
      ext_ev_s_ff <= ext_ev_m_ff;
      ext_ev_l_ff <= ext_ev_s_ff;
      regc_m_ff   <= regc_ch0_event;
      regc_s_ff   <= regc_m_ff;
      regc_l_ff   <= regc_s_ff;
    end
  end
  wire ext_rise  = ext_ev_s_ff & ~ext_ev_l_ff;
  wire ext_fall  = ~ext_ev_s_ff & ext_ev_l_ff;
  wire regc_rise = regc_s_ff & ~regc_l_ff;

  // A pulse narrower than one clock period can be missed, so a source clocked at
  // a rate above the system clock can lose captures.
  wire edge_rise = src_other ? ext_rise : pin_rise;
  wire edge_fall = src_other ? ext_fall : pin_fall;

  reg capt_hit;
  // Edge choice per capture code.
  always @* begin
    capt_hit = 1'b0;
    if (mode_capt) begin
      case (io_sel[2:0])
        3'b000:  capt_hit = edge_rise;
        3'b001:  capt_hit = edge_fall;
        3'b010,
        3'b011:  capt_hit = edge_rise | edge_fall;
        default: capt_hit = regc_rise;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Counter, compare and capture.
  // ---------------------------------------------------------------------------
  wire match_hit = ~mode_capt & run & (count_ff == regb_ff);
  wire cnt_wr    = wr_en & (paddr == `TCC_OFF_COUNT);
  wire regb_wr   = wr_en & (paddr == `TCC_OFF_REGB);

  // Capture wins over a software write landing in the same cycle.
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      count_ff <= {CNT_W{1'b0}};
      regb_ff  <= `TCC_RST_REGB;
    end else begin
      if (capt_hit && clr_on_b)
        count_ff <= {CNT_W{1'b0}};
      else if (cnt_wr)
        count_ff <= pwdata[CNT_W-1:0];
      else if (run)
        count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      if (capt_hit)
        regb_ff <= count_ff;
      else if (regb_wr)
        regb_ff <= pwdata[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive in compare mode.
  // ---------------------------------------------------------------------------
  wire ioctl_wr = wr_en & (paddr == `TCC_OFF_IOCTL);
  wire [3:0] new_sel = pwdata[`TCC_IOSEL_MSB:`TCC_IOSEL_LSB];
  reg  [7:0] nxt_ioctl_ff;
  always @* begin
    nxt_ioctl_ff = ioctl_ff;
    if (ioctl_wr)
      nxt_ioctl_ff = pwdata[7:0];
  end

  // The initial level is applied when the select field is written; the
  // enable is low while the pin is driven.
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ioctl_ff   <= `TCC_RST_IOCTL;
      pin_b_out  <= 1'b0;
      pin_b_oe_n <= 1'b1;
    end else begin
      ioctl_ff <= nxt_ioctl_ff;
      if (ioctl_wr) begin
        pin_b_out  <= new_sel[2];
        pin_b_oe_n <= new_sel[3] | (new_sel[1:0] == 2'b00);
      end else if (match_hit && !pin_b_oe_n) begin
        case (io_sel[1:0])
          2'b01:   pin_b_out <= 1'b0;
          2'b10:   pin_b_out <= 1'b1;
          2'b11:   pin_b_out <= ~pin_b_out;
          default: pin_b_out <= pin_b_out;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control, status and mask; a read of status clears it, set wins.
  // ---------------------------------------------------------------------------
  wire st_rd = rd_en & (paddr == `TCC_OFF_STATUS);
  wire [1:0] st_set = {capt_hit, match_hit};
  // Only the bits that this read returned are cleared.  prdata was loaded at
  // the setup edge, so an event that lands on that edge survives the read.
  wire [1:0] st_clr = st_rd ? prdata[1:0] : 2'b00;
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_ff   <= `TCC_RST_CTRL;
      mask_ff   <= 2'b00;
      status_ff <= 2'b00;
    end else begin
      if (wr_en && paddr == `TCC_OFF_CTRL)
        ctrl_ff <= pwdata[2:0];
      if (wr_en && paddr == `TCC_OFF_MASK)
        mask_ff <= pwdata[1:0];
      status_ff <= (status_ff & ~st_clr) | st_set;
    end
  end
  assign irq = |(status_ff & mask_ff);

  // ---------------------------------------------------------------------------
  // Read data, registered at the setup cycle.
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TCC_OFF_IOCTL:  prdata <= {24'h00_0000, ioctl_ff};
        `TCC_OFF_CTRL:   prdata <= {29'h0000_0000, ctrl_ff};
        `TCC_OFF_COUNT:  prdata <= {{(32-CNT_W){1'b0}}, count_ff};
        `TCC_OFF_REGB:   prdata <= {{(32-CNT_W){1'b0}}, regb_ff};
        `TCC_OFF_STATUS: prdata <= {30'h0000_0000, status_ff};
        `TCC_OFF_MASK:   prdata <= {30'h0000_0000, mask_ff};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // tcc_channel
`default_nettype wire

// File: tcc_map.vh
// Register map, field positions and reset values of the channel block.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TCC_OFF_IOCTL    12'h000
`define TCC_OFF_CTRL     12'h004
`define TCC_OFF_COUNT    12'h008
`define TCC_OFF_REGB     12'h00C
`define TCC_OFF_STATUS   12'h010
`define TCC_OFF_MASK     12'h014
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TCC_IOSEL_MSB    7
`define TCC_IOSEL_LSB    4
`define TCC_CTRL_RUN     0
`define TCC_CTRL_CLRB    1
`define TCC_CTRL_SRC     2
`define TCC_ST_MATCH     0
`define TCC_ST_CAPT      1
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TCC_RST_IOCTL    8'h00
`define TCC_RST_CTRL     3'h0
`define TCC_RST_REGB     16'hFFFF
`endif

// File: tcc_edge_det.v
// Pin synchroniser with rising and falling edge detection.
`default_nettype none
module tcc_edge_det (
  input  wire clk,
  input  wire rst_n,
  input  wire pin_in,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  // ---------------------------------------------------------------------------
  // Two stages, then a delayed copy for the edge compare.
  // ---------------------------------------------------------------------------
  // Only sync_ff and last_ff feed the edge logic, never meta_ff.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule // tcc_edge_det
`default_nettype wire

// File: tcc_channel_properties.sv
// Concurrent checks on the ports of the timer channel block.
`default_nettype none
`include "tcc_map.vh"
module tcc_channel_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pin_b_out,
  input wire logic        pin_b_oe_n,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Access cycle, and a write of io control within it.
  wire acc   = psel && penable;
  wire io_wr = acc && pwrite && paddr == `TCC_OFF_IOCTL;
  // Unmapped: beyond the last register, or not on a word boundary.
  wire bad_a = acc && (paddr > `TCC_OFF_MASK || paddr[1:0] != 2'b00);
  AST_READY: assert property (acc |-> pready)
    else $error("pready low in access");
  AST_UNMAPPED: assert property (bad_a |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  AST_ERR_ONLY: assert property (pslverr |-> bad_a)
    else $error("pslverr outside unmapped access");
  AST_CAPT_OFF: assert property (io_wr && pwdata[7] |=> pin_b_oe_n)
    else $error("pin driven in capture mode");
  AST_OFF_CODES: assert property (io_wr && pwdata[5:4] == 0 |=> pin_b_oe_n)
    else $error("pin driven for an off code");
  AST_INIT_LVL: assert property (io_wr && !pwdata[7] && pwdata[5:4] != 0
    |=> !pin_b_oe_n && pin_b_out == $past(pwdata[6]))
    else $error("wrong initial pin level");
  AST_DRIVE_CAUSE: assert property ($fell(pin_b_oe_n) |-> $past(io_wr))
    else $error("pin driven without io write");
  // A pin change that no io write explains must happen while the pin is driven.
  AST_PIN_HOLD: assert property (!$stable(pin_b_out) && !$past(io_wr)
    |-> !$past(pin_b_oe_n))
    else $error("pin level moved while undriven");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(acc))
    else $error("irq fell without a bus access");
endmodule // tcc_channel_properties
bind tcc_channel tcc_channel_properties u_props (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n), .irq(irq));
`default_nettype wire

// File: tcc_pin_src.sv
// Model of the external source that shares the channel's capture pin.
`default_nettype none
module tcc_pin_src (
  input  wire logic src_lvl,
  input  wire logic pin_b_out,
  input  wire logic pin_b_oe_n,
  output wire logic pin_b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The source yields while the channel drives, so contention is avoided.
  assign pin_b_in = pin_b_oe_n ? src_lvl : pin_b_out;
endmodule // tcc_pin_src
`default_nettype wire

// File: tcc_channel_test.sv
// Self-checking bench for the timer channel capture and compare block.
`default_nettype none
`include "tcc_map.vh"
module tcc_channel_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        src = 0, regc_ev = 0, oth_ev = 0, se, pready, pslverr;
  logic        pin_in, pin_out, pin_oe_n, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0]  c;
  int          miscompares = 0, checks = 0;
  always #20 clk = ~clk;
  tcc_channel dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_b_in(pin_in),
    .pin_b_out(pin_out), .pin_b_oe_n(pin_oe_n), .regc_ch0_event(regc_ev),
    .other_ch_event(oth_ev), .irq(irq));
  tcc_pin_src pm (.src_lvl(src), .pin_b_out(pin_out),
    .pin_b_oe_n(pin_oe_n), .pin_b_in(pin_in));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One transfer; a spare edge after it keeps psel from being set twice.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    wt(8);
    rst_n <= 1;
    wt(3);
    apb(0, `TCC_OFF_REGB, 0);
    chk("regb", 32'h0000_FFFF, q);
    chk("oe_n", 1, pin_oe_n);
    apb(1, 12'h040, 32'h0000_00F0);
    apb(0, 12'h040, 0);
    chk("slverr", 1, se);
    chk("unmapped", 0, q);
    apb(0, `TCC_OFF_IOCTL, 0);
    chk("ioctl", 0, q);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      c = k[3:0];
      apb(1, `TCC_OFF_CTRL, 0);
      apb(1, `TCC_OFF_COUNT, 0);
      apb(1, `TCC_OFF_REGB, 32'h0000_0010);
      apb(1, `TCC_OFF_IOCTL, {24'h0, c, 4'h0});
      chk("oe_n", c[1:0] == 0, pin_oe_n);
      if (c[1:0] != 0) chk("init", c[2], pin_out);
      apb(0, `TCC_OFF_STATUS, 0);
      apb(1, `TCC_OFF_CTRL, 1);
      q = 0;
      for (int i = 0; i < 40 && q[0] !== 1'b1; i++)
        apb(0, `TCC_OFF_STATUS, 0);
      chk("match", 1, q[0]);
      apb(1, `TCC_OFF_CTRL, 0);
      if (c[1:0] != 0) chk("pin", c[1] & ~(c[0] & c[2]), pin_out);
    end
    $display("test compare done");
    apb(1, `TCC_OFF_MASK, 2);
    for (int k = 0; k < 4; k++) begin
      c = (k == 3) ? 4'hC : 4'h8 + k[3:0];
      apb(1, `TCC_OFF_CTRL, 0);
      apb(1, `TCC_OFF_COUNT, 32'h0000_1230 + k);
      apb(1, `TCC_OFF_IOCTL, {24'h0, c, 4'h0});
      chk("oe_n", 1, pin_oe_n);
      src <= (c == 4'h8);
      wt(6);
      apb(0, `TCC_OFF_STATUS, 0);
      src <= ~src;
      wt(6);
      chk("edge1", c == 4'hA, irq);
      if (c != 4'hA) begin
        if (c == 4'hC) regc_ev <= 1;
        else src <= ~src;
        wt(6);
        chk("edge2", 1, irq);
      end
      apb(0, `TCC_OFF_STATUS, 0);
      chk("status", 2, q);
      chk("irq", 0, irq);
      apb(0, `TCC_OFF_REGB, 0);
      chk("regb", 32'h0000_1230 + k, q);
      regc_ev <= 0;
    end
    $display("test capture done");
    apb(1, `TCC_OFF_IOCTL, 32'h0000_0090);
    apb(1, `TCC_OFF_CTRL, 3);
    wt(30);
    src <= 0;
    wt(4);
    apb(0, `TCC_OFF_COUNT, 0);
    chk("cleared", 1, q < 32'd12);
    apb(1, `TCC_OFF_IOCTL, 32'h0000_0080);
    // A slow level stands in for the other channel, never the raw clock.
    apb(1, `TCC_OFF_CTRL, 4);
    apb(1, `TCC_OFF_COUNT, 32'h0000_0555);
    apb(0, `TCC_OFF_STATUS, 0);
    src <= 1;
    wt(6);
    chk("pin ignored", 0, irq);
    oth_ev <= 1;
    wt(6);
    chk("other", 1, irq);
    apb(0, `TCC_OFF_REGB, 0);
    chk("regb", 32'h0000_0555, q);
    $display("test source done");
    conclude();
  end
  // The run needs under a thousand cycles; this limit leaves wide margin.
  initial begin
    #(40 * 20000);
    miscompares++;
    conclude();
  end
endmodule // tcc_channel_test
`default_nettype wire
